/* pfd_regs.svh */
// register map, field positions and reset values of the frequency divider
// assumes a 32-bit axi4-lite bus, one register per aligned word
`ifndef PFD_REGS_SVH
`define PFD_REGS_SVH

`define PFD_IDX_CONTROL 8'h2E
`define PFD_IDX_DIVISOR 8'h2F
`define PFD_ADDR_CONTROL 8'hB8
`define PFD_ADDR_DIVISOR 8'hBC

`define PFD_BIT_ENABLE 4
`define PFD_BIT_PRE_LO 5
`define PFD_BIT_PRE_HI 6
`define PFD_BIT_SOURCE 7

`define PFD_RST_CONTROL 4'h0
`define PFD_RST_DIVISOR 8'h00

`define PFD_FAST_DIV 2'h3
`define PFD_RESP_OKAY 2'h0
`define PFD_RESP_SLVERR 2'h2

`endif

/* pfd_pkg.sv */
// types shared by the frequency divider
// assumes nothing beyond a systemverilog compiler
package pfd_pkg;
    typedef logic [1:0] pfd_prescale_t;
    typedef logic [7:0] pfd_byte_t;
endpackage

/* pfd_top.sv */
// programmable frequency divider with axi4-lite register access
// assumes source clock pins are slow against aclk (40 MHz)
// What this block does
// - tone output runs only while control enable bit 4 is one.
// - with enable zero, tone output pin is held low.
// - control bits 6:5 pick prescale of 1, 2, 4 or 8.
// - control bit 7 picks fast clock over four, else 32768 Hz clock.
// - prescaler feeds a general counter ended by 8-bit divisor register.
// - divisor writes are ignored while disabled; software enables first.
// - disabled divider clears divisor register to zero.
// - tone frequency is prescaler rate over twice the sum of divisor and one.
// - control bits 3 to 0 always read as zero.
`timescale 1ns/100ps
`include "pfd_regs.svh"

module pfd_top
    import pfd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        fast_clk_pin,
    input  wire logic        slow_clk_pin,
    output logic             tone_output_pin
);

    function automatic logic [2:0] pre_mask(input pfd_prescale_t code);
        pre_mask = 3'((4'h1 << code) - 4'h1);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // control fields
    logic          divider_source_select;
    pfd_prescale_t prescale_sel;
    logic          divider_output_enable;
    pfd_byte_t     divider_divisor;

    // write path
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr_q;
    logic [7:0]  w_data_q;
    logic        w_lane_q;
    wire         wr_fire   = aw_held && w_held && !bvalid;
    wire         wr_ctrl   = wr_fire && hit(aw_addr_q, `PFD_ADDR_CONTROL) && w_lane_q;
    wire         wr_div    = wr_fire && hit(aw_addr_q, `PFD_ADDR_DIVISOR) && w_lane_q;
    wire         wr_mapped = hit(aw_addr_q, `PFD_ADDR_CONTROL)
                           || hit(aw_addr_q, `PFD_ADDR_DIVISOR);

    assign awready = !aw_held;
    assign wready  = !w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held   <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held   <= 1'b1;
                w_data_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `PFD_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? `PFD_RESP_OKAY : `PFD_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // register storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {divider_source_select, prescale_sel, divider_output_enable} <= `PFD_RST_CONTROL;
        end else if (wr_ctrl) begin
            divider_output_enable <= w_data_q[`PFD_BIT_ENABLE];
            prescale_sel          <= w_data_q[`PFD_BIT_PRE_HI:`PFD_BIT_PRE_LO];
            divider_source_select <= w_data_q[`PFD_BIT_SOURCE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divider_divisor <= `PFD_RST_DIVISOR;
        end else if (!divider_output_enable) begin
            divider_divisor <= `PFD_RST_DIVISOR;
        end else if (wr_div) begin
            divider_divisor <= w_data_q;
        end
    end

    // read path
    wire        rd_ctrl = hit(araddr, `PFD_ADDR_CONTROL);
    wire        rd_div  = hit(araddr, `PFD_ADDR_DIVISOR);
    wire [7:0]  ctrl_rd = {divider_source_select, prescale_sel,
                           divider_output_enable, 4'h0};
    logic       rd_was_ctrl;

    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid      <= 1'b0;
            rdata       <= 32'h00000000;
            rresp       <= `PFD_RESP_OKAY;
            rd_was_ctrl <= 1'b0;
        end else if (arvalid && arready) begin
            rvalid      <= 1'b1;
            rd_was_ctrl <= rd_ctrl;
            rdata       <= {24'h000000, rd_ctrl ? ctrl_rd : (rd_div ? divider_divisor : 8'h00)};
            rresp       <= (rd_ctrl || rd_div) ? `PFD_RESP_OKAY : `PFD_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // pin synchronisers: a level counts once stages two and three agree
    logic [2:0] fast_sync;
    logic [2:0] slow_sync;
    logic       fast_lvl;
    logic       slow_lvl;
    wire        fast_rise = (fast_sync[1] == fast_sync[2]) && fast_sync[1] && !fast_lvl;
    wire        slow_rise = (slow_sync[1] == slow_sync[2]) && slow_sync[1] && !slow_lvl;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_sync <= 3'h0;
            slow_sync <= 3'h0;
            fast_lvl  <= 1'b0;
            slow_lvl  <= 1'b0;
        end else begin
            fast_sync <= {fast_sync[1:0], fast_clk_pin};
            slow_sync <= {slow_sync[1:0], slow_clk_pin};
            if (fast_sync[1] == fast_sync[2]) fast_lvl <= fast_sync[1];
            if (slow_sync[1] == slow_sync[2]) slow_lvl <= slow_sync[1];
        end
    end

    // fast clock over four, then source select
    logic [1:0] fast_cnt;
    wire        fast_tick = fast_rise && (fast_cnt == `PFD_FAST_DIV);
    wire        src_tick  = divider_source_select ? fast_tick : slow_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_cnt <= 2'h0;
        end else if (fast_rise) begin
            fast_cnt <= fast_cnt + 2'h1;
        end
    end

    // prescaler and general counter
    logic [2:0] pre_cnt;
    logic [7:0] gen_cnt;
    wire        pre_tick = src_tick && ((pre_cnt & pre_mask(prescale_sel))
                           == pre_mask(prescale_sel));
    // >= so a divisor lowered mid-count cannot strand the counter
    wire        term     = pre_tick && (gen_cnt >= divider_divisor);

    always_ff @(posedge aclk) begin
        if (!aresetn || !divider_output_enable) begin
            pre_cnt         <= 3'h0;
            gen_cnt         <= 8'h00;
            tone_output_pin <= 1'b0;
        end else begin
            if (src_tick) pre_cnt <= pre_cnt + 3'h1;
            if (term) begin
                gen_cnt         <= 8'h00;
                tone_output_pin <= !tone_output_pin;
            end else if (pre_tick) begin
                gen_cnt <= gen_cnt + 8'h01;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_blocked_write;
        wr_div && !divider_output_enable;
    endsequence

    sequence s_enabled_write;
        wr_div && divider_output_enable;
    endsequence

    sequence s_disable_seen;
        divider_output_enable ##1 !divider_output_enable;
    endsequence

    // divisor zero at rate one: every source tick is a terminal count
    sequence s_fastest_tick;
        divider_output_enable && divider_divisor == 8'h00
        && prescale_sel == 2'h0 && src_tick;
    endsequence

    sequence s_unmapped_read;
        arvalid && arready && !(rd_ctrl || rd_div);
    endsequence

    // pin side
    a_tone_held_low: assert property (
        !$past(divider_output_enable) |-> !tone_output_pin)
        else $error("tone not low while disabled");
    a_tone_only_on: assert property (
        $rose(tone_output_pin) |-> $past(divider_output_enable))
        else $error("tone rose while disabled");
    a_disable_clears: assert property (
        s_disable_seen |=> !tone_output_pin && gen_cnt == 8'h00 && pre_cnt == 3'h0)
        else $error("disable left the counters running");
    a_fast_edge_once: assert property (fast_rise |=> !fast_rise)
        else $error("fast pin edge counted twice");
    a_slow_edge_once: assert property (slow_rise |=> !slow_rise)
        else $error("slow pin edge counted twice");
    a_source_select: assert property (
        src_tick |-> (divider_source_select ? fast_rise : slow_rise))
        else $error("wrong divider source");

    // prescaler and counter
    a_prescale_one: assert property (src_tick && prescale_sel == 2'h0 |-> pre_tick)
        else $error("prescale by one skipped a tick");
    a_prescale_two: assert property (
        src_tick && prescale_sel == 2'h1 |-> pre_tick == pre_cnt[0])
        else $error("prescale by two off phase");
    a_prescale_four: assert property (
        pre_tick && prescale_sel == 2'h2 |-> pre_cnt[1:0] == 2'h3)
        else $error("prescale by four off phase");
    a_prescale_eight: assert property (
        pre_tick && prescale_sel == 2'h3 |-> pre_cnt == 3'h7)
        else $error("prescale by eight off phase");
    a_count_wrap: assert property (term |=> gen_cnt == 8'h00)
        else $error("counter did not restart at the divisor");
    a_toggle_cause: assert property (
        divider_output_enable && $past(divider_output_enable)
        && $changed(tone_output_pin) |-> $past(term))
        else $error("tone toggled without terminal count");
    a_fastest_toggle: assert property (s_fastest_tick |=> $changed(tone_output_pin))
        else $error("tone missed a toggle at divisor zero");
    a_count_bound: assert property (
        pre_tick && gen_cnt < divider_divisor
        |=> !$changed(tone_output_pin) || !divider_output_enable)
        else $error("tone toggled before divisor reached");

    // register side
    a_divisor_cleared: assert property (
        !divider_output_enable |=> divider_divisor == 8'h00)
        else $error("divisor not cleared while disabled");
    a_write_ignored: assert property (s_blocked_write |=> divider_divisor == 8'h00)
        else $error("divisor took write while disabled");
    a_write_taken: assert property (
        s_enabled_write |=> divider_divisor == $past(w_data_q))
        else $error("divisor missed enabled write");
    a_ctrl_taken: assert property (
        wr_ctrl |=> divider_output_enable == $past(w_data_q[`PFD_BIT_ENABLE])
        && divider_source_select == $past(w_data_q[`PFD_BIT_SOURCE]))
        else $error("control write not taken");
    a_lane_dropped: assert property (
        wr_fire && !w_lane_q && divider_output_enable
        |=> $stable(divider_divisor) && $stable(divider_output_enable))
        else $error("write with lane off changed a register");
    a_ctrl_low_zero: assert property (rvalid && rd_was_ctrl |-> rdata[3:0] == 4'h0)
        else $error("control low bits not zero");
    a_unmapped_read: assert property (
        s_unmapped_read |=> rresp == `PFD_RESP_SLVERR && rdata == 32'h00000000)
        else $error("unmapped read not refused");

    // bus side: an answer stands until it is taken
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_write_answer: assert property (wr_fire |=> bvalid)
        else $error("write answer missing");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");

endmodule

/* pfd_sounder.sv */
// sounder on the tone pin: times each half period between pin edges
// assumes a clean digital tone level and a 1 ns time unit
`timescale 1ns/100ps
module pfd_sounder (
    input  wire logic tone_output_pin,
    output int        half_ns,
    output int        edges
);
    realtime last_t = 0.0;
    initial edges = 0;
    // a sounder only listens, so nothing is driven back
    always @(tone_output_pin) begin
        half_ns = int'($realtime - last_t);
        last_t = $realtime;
        edges = edges + 1;
    end
endmodule

/* testbench.sv */
// bench of the frequency divider: axi4-lite master, source pins, sounder
// assumes source pins far slower than aclk, as the sync chain needs
`timescale 1ns/100ps
`include "pfd_regs.svh"
module testbench;
    import pfd_pkg::*;
    typedef struct {pfd_byte_t c; pfd_byte_t d; int half;} pfd_row_t;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, tone, fast_clk_pin, slow_clk_pin;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    int          failures = 0, check_count = 0, cycles = 0, half_ns, edges, e0, n;
    pfd_row_t    rows [7] = '{'{8'h10, 8'h00, 530}, '{8'h30, 8'h02, 3180},
        '{8'h50, 8'h01, 4240}, '{8'h70, 8'h00, 4240}, '{8'h90, 8'h03, 3360},
        '{8'hF0, 8'h00, 6720}, '{8'h90, 8'hFF, 215040}};

    pfd_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .fast_clk_pin(fast_clk_pin),
        .slow_clk_pin(slow_clk_pin), .tone_output_pin(tone));
    pfd_sounder u_snd (.tone_output_pin(tone), .half_ns(half_ns), .edges(edges));

    // source pins run at odd periods so they drift against aclk
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        fast_clk_pin = 1'b0;
        forever #105 fast_clk_pin = ~fast_clk_pin;
    end
    initial begin
        slow_clk_pin = 1'b0;
        forever #265 slow_clk_pin = ~slow_clk_pin;
    end

    task automatic end_sim();
        $display("failures %0d check_count %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // edges land on aclk after a sync chain, so allow about two cycles
    task automatic chk_near(string what, int exp, int seen);
        check_count++;
        if (seen < exp - 60 || seen > exp + 60) begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    // each request stands until the rising edge that takes it; only the timeout ends a wait
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bready && bvalid) begin
                resp = bresp;
                done = 1'b1;
            end
        end
        bready <= 1'b0;
        // one idle edge so a following call never reassigns in this step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rready && rvalid) begin
                got  = rdata;
                resp = rresp;
                done = 1'b1;
            end
        end
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        wstrb <= 4'hF;
        rd(`PFD_ADDR_CONTROL);
        chk("control reset", 32'h00000000, got);
        wr(`PFD_ADDR_CONTROL, 8'hFF);
        rd(`PFD_ADDR_CONTROL);
        chk("control low bits", 32'h000000F0, got);
        foreach (rows[i]) begin
            wr(`PFD_ADDR_CONTROL, 8'h00);
            wr(`PFD_ADDR_CONTROL, rows[i].c);
            wr(`PFD_ADDR_DIVISOR, rows[i].d);
            rd(`PFD_ADDR_DIVISOR);
            chk("divisor", {24'h000000, rows[i].d}, got);
            e0 = edges;
            for (n = 0; n < 40000 && edges < e0 + 3; n++)
                @(posedge aclk);
            chk("tone edges", e0 + 3, edges);
            chk_near("half period ns", rows[i].half, half_ns);
        end
        wr(`PFD_ADDR_CONTROL, 8'h00);
        rd(`PFD_ADDR_DIVISOR);
        chk("divisor cleared", 32'h00000000, got);
        wr(`PFD_ADDR_DIVISOR, 8'h5A);
        chk("disabled write resp", `PFD_RESP_OKAY, resp);
        rd(`PFD_ADDR_DIVISOR);
        chk("disabled write dropped", 32'h00000000, got);
        e0 = edges;
        repeat (2000) @(posedge aclk);
        chk("tone edges while off", e0, edges);
        chk("tone level while off", 32'h00000000, {31'h0, tone});
        rd(8'h40);
        chk("unmapped resp", `PFD_RESP_SLVERR, resp);
        wr(8'h40, 8'h00);
        chk("unmapped write resp", `PFD_RESP_SLVERR, resp);
        wr(`PFD_ADDR_CONTROL, 8'h10);
        wr(`PFD_ADDR_DIVISOR, 8'h21);
        wstrb <= 4'hE;
        wr(`PFD_ADDR_DIVISOR, 8'h5A);
        wstrb <= 4'hF;
        rd(`PFD_ADDR_DIVISOR);
        chk("lane zero dropped", 32'h00000021, got);
        // reset with the tone high must drop the pin and the registers
        while (tone !== 1'b1)
            @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk("tone after reset", 32'h00000000, {31'h0, tone});
        rd(`PFD_ADDR_CONTROL);
        chk("control after reset", 32'h00000000, got);
        rd(`PFD_ADDR_DIVISOR);
        chk("divisor after reset", 32'h00000000, got);
        end_sim();
    end
endmodule
